// File: verilog/bta_pkg.sv
// Functional notes
// - One threshold array of 5,120 entries holds every accounting limit.
// - Entries 0..455: ingress memory reservation per port/priority at 8P+Q.
// - Ingress memory shared limit per priority sits at entry 496+Q.
// - Entries 508..511: ingress shared limits for drop levels 1,2,3,0.
// - Per-port ingress reservation shared by priorities at entry 512+P.
// - Ingress reference limits repeat that layout 1,024 entries higher.
// - Egress memory limits repeat that layout 2048 entries higher.
// - Egress reference limits repeat that layout 3,072 entries higher.
// - Pause limits at +4,096 on ingress memory; pause once none left.
// - The pause scheme never blocks or discards; it only requests pause.
// - Each entry keeps a readable peak of values compared against it.
// - Each entry keeps a readable value currently compared against it.
// - 72 early-discard profiles: 3 groups x 3 drop levels x 8 priorities.
// - Per port: early-discard group and pause enable.
// - Per class enable turns reservation accounting on.
// - Per port: yellow may use reserve; ingress/egress share blocks.
// - Sticky per-port drop flag, held until software clears it.
// - Count frames not delivered to the processor due to congestion.
// - Count all frame copies placed into egress queues.
// - Count frame copies discarded for forward pressure, all ports.
// - Software reads ingress queue size and free reference count.
// - Each profile has a zero-probability and a certain-drop level.
// - Drop level zero is green and never early-discarded.
package bta_pkg;

  // ==========================================================
  // Threshold array layout
  localparam int unsigned THR_ENTRIES   = 5120;
  localparam int unsigned IDX_W         = 13;
  localparam int unsigned BLK_INGR_REF  = 1024;
  localparam int unsigned BLK_EGR_MEM   = 2048;
  localparam int unsigned BLK_EGR_REF   = 3072;
  localparam int unsigned BLK_PAUSE     = 4096;
  localparam int unsigned SUB_PRIO_SH   = 496;
  localparam int unsigned SUB_DL_SH     = 508;
  localparam int unsigned SUB_PORT_SH   = 512;
  localparam int unsigned SUB_PORT_LAST = 568;
  localparam int unsigned NUM_PRIO      = 8;
  localparam int unsigned NUM_PROFILES  = 72;

  // ==========================================================
  // Register word addresses
  localparam logic [15:0] A_CFG_BASE   = 16'h0000;
  localparam logic [15:0] A_PEAK_BASE  = 16'h2000;
  localparam logic [15:0] A_CUR_BASE   = 16'h4000;
  localparam logic [15:0] A_PROF_BASE  = 16'h6000;
  localparam logic [15:0] A_PORT_BASE  = 16'h6100;
  localparam logic [15:0] A_CLASS_EN   = 16'h6200;
  localparam logic [15:0] A_STICKY_LO  = 16'h6201;
  localparam logic [15:0] A_STICKY_HI  = 16'h6202;
  localparam logic [15:0] A_CPU_DROP   = 16'h6203;
  localparam logic [15:0] A_ENQ_CNT    = 16'h6204;
  localparam logic [15:0] A_PRESS_DROP = 16'h6205;
  localparam logic [15:0] A_IQ_SIZE    = 16'h6206;
  localparam logic [15:0] A_FREE_REF   = 16'h6207;

  // Port mode word fields
  localparam int unsigned PM_GRP_LSB   = 0;
  localparam int unsigned PM_PFC_BIT   = 2;
  localparam int unsigned PM_YEL_BIT   = 3;
  localparam int unsigned PM_IGR_BIT   = 4;
  localparam int unsigned PM_EGR_BIT   = 5;
  localparam logic [1:0]  GRP_NONE     = 2'h3;
  localparam logic [5:0]  PM_RST       = 6'h03;
  localparam logic [7:0]  CLASS_EN_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
    logic [15:0]      value;
  } bta_cmp_req_s;

  typedef struct packed {
    logic             valid;
    logic             exhausted;
    logic             blocks;
  } bta_cmp_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] port;
    logic [2:0] prio;
    logic [1:0] dropLevel;
    logic [15:0] usage;
  } bta_red_req_s;

  typedef struct packed {
    logic       valid;
    logic       discard;
    logic       yellowUsesReserved;
    logic       ingressShareBlock;
    logic       egressShareBlock;
    logic       classReservationOn;
  } bta_red_rsp_s;

  typedef struct packed {
    logic       dropValid;
    logic [5:0] dropPort;
    logic       cpuDrop;
    logic       pressureDrop;
    logic       enqueued;
  } bta_event_s;

endpackage

// File: verilog/bta_threshold_accounting.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module bta_threshold_accounting
  import bta_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 57,
  parameter int unsigned THR_W     = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Register port
  input  wire logic [15:0]                 regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  // Forwarder side
  input  wire bta_cmp_req_s                cmpReq,
  output bta_cmp_rsp_s                     cmpRsp,
  input  wire bta_red_req_s                redReq,
  output bta_red_rsp_s                     redRsp,
  input  wire bta_event_s                  fwdEvent,
  input  wire logic [15:0]                 ingressQueueSize,
  input  wire logic [15:0]                 freeReferenceCount,
  // Pause requests toward ports, bit 8*port+prio
  output logic      [NUM_PORTS*NUM_PRIO-1:0] pauseRequest
);

  // ==========================================================
  // Storage
  logic [THR_W-1:0] thresholdConfigArray   [THR_ENTRIES];
  logic [THR_W-1:0] thresholdPeakStatus    [THR_ENTRIES];
  logic [THR_W-1:0] thresholdCurrentStatus [THR_ENTRIES];
  logic [31:0]      earlyDiscardProfile    [NUM_PROFILES];
  logic [5:0]       portMode_ff            [NUM_PORTS];
  logic [7:0]       classReservationEnable_ff;
  logic [63:0]      portDropStickyFlags_ff;
  logic [31:0]      processorDropCounter_ff;
  logic [31:0]      enqueuedCopyCounter_ff;
  logic [31:0]      pressureDropCounter_ff;
  logic [15:0]      lfsr_ff;

  // ==========================================================
  // Address decode
  logic [15:0] offCfg;
  logic [15:0] offPeak;
  logic [15:0] offCur;
  logic [15:0] offProf;
  logic [15:0] offPort;
  logic        hitCfg;
  logic        hitPeak;
  logic        hitCur;
  logic        hitProf;
  logic        hitPort;

  assign offCfg  = regAddr - A_CFG_BASE;
  assign offPeak = regAddr - A_PEAK_BASE;
  assign offCur  = regAddr - A_CUR_BASE;
  assign offProf = regAddr - A_PROF_BASE;
  assign offPort = regAddr - A_PORT_BASE;
  assign hitCfg  = regAddr >= A_CFG_BASE
                && offCfg < 16'(THR_ENTRIES);
  assign hitPeak = regAddr >= A_PEAK_BASE
                && offPeak < 16'(THR_ENTRIES);
  assign hitCur  = regAddr >= A_CUR_BASE
                && offCur < 16'(THR_ENTRIES);
  assign hitProf = regAddr >= A_PROF_BASE
                && offProf < 16'(NUM_PROFILES);
  assign hitPort = regAddr >= A_PORT_BASE
                && offPort < 16'(NUM_PORTS);

  // ==========================================================
  // Threshold configuration array
  always_ff @(posedge clk) begin
    if (regWr && hitCfg) begin
      thresholdConfigArray[offCfg[IDX_W-1:0]] <= regWdata[THR_W-1:0];
    end
  end

  // ==========================================================
  // Comparison against one threshold entry
  logic [THR_W-1:0] cmpThr;
  logic [THR_W-1:0] cmpVal;
  logic             cmpExhausted;
  logic             cmpIsPause;
  logic [IDX_W-1:0] pauseSub;

  // All blocks share one layout
  assign cmpThr       =
    thresholdConfigArray[cmpReq.index];
  assign cmpVal       = cmpReq.value[THR_W-1:0];
  // No memory left under this limit once usage reaches it
  assign cmpExhausted = cmpVal >= cmpThr;
  assign cmpIsPause   = cmpReq.index >= IDX_W'(BLK_PAUSE);
  assign pauseSub     = cmpReq.index - IDX_W'(BLK_PAUSE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpRsp <= '0;
    end else begin
      cmpRsp.valid     <= cmpReq.valid;
      cmpRsp.exhausted <= cmpReq.valid && cmpExhausted;
      // Pause block never stops a copy
      cmpRsp.blocks    <= cmpReq.valid && cmpExhausted && !cmpIsPause;
    end
  end

  // Current compared value per entry
  always_ff @(posedge clk) begin
    if (cmpReq.valid) begin
      thresholdCurrentStatus[cmpReq.index] <= cmpVal;
    end
  end

  // Peak: a comparison hitting the entry being written still counts
  // Peak is never reset; software seeds it
  logic             peakWrHit;
  logic [THR_W-1:0] peakWrVal;
  assign peakWrHit = regWr && hitPeak;
  assign peakWrVal = regWdata[THR_W-1:0];

  always_ff @(posedge clk) begin
    if (peakWrHit) begin
      if (cmpReq.valid && cmpReq.index == offPeak[IDX_W-1:0]
          && cmpVal > peakWrVal) begin
        thresholdPeakStatus[offPeak[IDX_W-1:0]] <= cmpVal;
      end else begin
        thresholdPeakStatus[offPeak[IDX_W-1:0]] <= peakWrVal;
      end
    end
    if (cmpReq.valid && !(peakWrHit
        && cmpReq.index == offPeak[IDX_W-1:0])) begin
      if (cmpVal > thresholdPeakStatus[cmpReq.index]) begin
        thresholdPeakStatus[cmpReq.index] <= cmpVal;
      end
    end
  end

  // ==========================================================
  // Pause requests, one bit per port and priority
  logic hitColour;
  assign hitColour = cmpReq.valid && cmpIsPause
                  && pauseSub >= IDX_W'(SUB_DL_SH)
                  && pauseSub < IDX_W'(SUB_PORT_SH);

  genvar gp;
  genvar gq;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic hitPortSh;
      // One entry covers every priority of the port
      assign hitPortSh = cmpReq.valid && cmpIsPause
                      && pauseSub == IDX_W'(SUB_PORT_SH + gp);
      for (gq = 0; gq < NUM_PRIO; gq++) begin : g_prio
        logic hitPair;
        logic hitPrio;
        logic hit;
        assign hitPair = cmpReq.valid && cmpIsPause
                      && pauseSub == IDX_W'(NUM_PRIO*gp + gq);
        assign hitPrio = cmpReq.valid && cmpIsPause
                      && pauseSub == IDX_W'(SUB_PRIO_SH + gq);
        // Any of the four entry kinds moves the bit
        assign hit = hitPair || hitPrio || hitColour || hitPortSh;
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            pauseRequest[NUM_PRIO*gp+gq] <= 1'b0;
          end else if (!portMode_ff[gp][PM_PFC_BIT]) begin
            pauseRequest[NUM_PRIO*gp+gq] <= 1'b0;
          end else if (hit) begin
            // Set on exhaustion, withdrawn when room returns
            pauseRequest[NUM_PRIO*gp+gq] <= cmpExhausted;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Early-discard profiles and per-port switch settings
  always_ff @(posedge clk) begin
    if (regWr && hitProf) begin
      earlyDiscardProfile[offProf[6:0]] <= regWdata;
    end
  end

  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_pmode
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          portMode_ff[gp] <= PM_RST;
        end else if (regWr && hitPort && offPort == 16'(gp)) begin
          portMode_ff[gp] <= regWdata[5:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      classReservationEnable_ff <= CLASS_EN_RST;
    end else if (regWr && regAddr == A_CLASS_EN) begin
      classReservationEnable_ff <= regWdata[7:0];
    end
  end

  // ==========================================================
  // Early-discard decision
  // One shared source; draws are not independent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0],
                  lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end

  logic [5:0]  redPort;
  logic [5:0]  redMode;
  logic [1:0]  redGroup;
  logic [6:0]  profIdx;
  logic [31:0] prof;
  logic [15:0] lowLvl;
  logic [15:0] highLvl;
  logic [15:0] span;
  logic [15:0] above;
  logic [31:0] scaled;
  logic        redDiscard;

  // Unknown ports fall back to port 0
  assign redPort  = redReq.port < 6'(NUM_PORTS) ? redReq.port : 6'h00;
  assign redMode  = portMode_ff[redPort];
  assign redGroup = redMode[PM_GRP_LSB+1:PM_GRP_LSB];
  // Group-major, then drop level, then priority
  assign profIdx  = 7'(redGroup) * 7'd24
                  + 7'(redReq.dropLevel - 2'h1) * 7'd8
                  + 7'(redReq.prio);
  assign prof     = earlyDiscardProfile[profIdx];
  assign lowLvl   = prof[15:0];
  assign highLvl  = prof[31:16];
  assign span     = highLvl - lowLvl;
  assign above    = redReq.usage - lowLvl;
  assign scaled   = lfsr_ff * span;

  always_comb begin
    redDiscard = 1'b0;
    if (redReq.dropLevel != 2'h0 && redGroup != GRP_NONE) begin
      if (redReq.usage >= highLvl) begin
        redDiscard = 1'b1;
      end else if (redReq.usage > lowLvl) begin
        // Probability rises linearly between the two levels
        redDiscard = scaled[31:16] < above;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      redRsp <= '0;
    end else begin
      redRsp.valid              <= redReq.valid;
      redRsp.discard            <= redReq.valid && redDiscard;
      redRsp.yellowUsesReserved <= redMode[PM_YEL_BIT];
      redRsp.ingressShareBlock  <= redMode[PM_IGR_BIT];
      redRsp.egressShareBlock   <= redMode[PM_EGR_BIT];
      redRsp.classReservationOn <=
        classReservationEnable_ff[redReq.prio];
    end
  end

  // ==========================================================
  // Monitoring: sticky flags, write 1 to clear, set wins
  logic [63:0] stickySet;
  logic [63:0] stickyClr;

  always_comb begin
    stickySet = '0;
    stickyClr = '0;
    if (fwdEvent.dropValid && fwdEvent.dropPort < 6'(NUM_PORTS)) begin
      stickySet[fwdEvent.dropPort] = 1'b1;
    end
    if (regWr && regAddr == A_STICKY_LO) begin
      stickyClr[31:0] = regWdata;
    end
    if (regWr && regAddr == A_STICKY_HI) begin
      stickyClr[63:32] = regWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portDropStickyFlags_ff <= '0;
    end else begin
      portDropStickyFlags_ff <=
        (portDropStickyFlags_ff & ~stickyClr) | stickySet;
    end
  end

  // Each counter clears on a write to its own address; an event in that cycle counts as one
  // Wrap silently; poll before overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      processorDropCounter_ff <= '0;
    end else if (regWr && regAddr == A_CPU_DROP) begin
      processorDropCounter_ff <= 32'(fwdEvent.cpuDrop);
    end else if (fwdEvent.cpuDrop) begin
      processorDropCounter_ff <= processorDropCounter_ff + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enqueuedCopyCounter_ff <= '0;
    end else if (regWr && regAddr == A_ENQ_CNT) begin
      enqueuedCopyCounter_ff <= 32'(fwdEvent.enqueued);
    end else if (fwdEvent.enqueued) begin
      enqueuedCopyCounter_ff <= enqueuedCopyCounter_ff + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pressureDropCounter_ff <= '0;
    end else if (regWr && regAddr == A_PRESS_DROP) begin
      pressureDropCounter_ff <= 32'(fwdEvent.pressureDrop);
    end else if (fwdEvent.pressureDrop) begin
      pressureDropCounter_ff <= pressureDropCounter_ff + 32'h1;
    end
  end

  // ==========================================================
  // Read path, data one cycle after the strobe
  // Zero outside the read slot
  logic [31:0] nxt_regRdata;

  always_comb begin
    nxt_regRdata = 32'h0;
    if (hitCfg) begin
      nxt_regRdata = 32'(thresholdConfigArray[offCfg[IDX_W-1:0]]);
    end else if (hitPeak) begin
      nxt_regRdata = 32'(thresholdPeakStatus[offPeak[IDX_W-1:0]]);
    end else if (hitCur) begin
      nxt_regRdata = 32'(thresholdCurrentStatus[offCur[IDX_W-1:0]]);
    end else if (hitProf) begin
      nxt_regRdata = earlyDiscardProfile[offProf[6:0]];
    end else if (hitPort) begin
      nxt_regRdata = 32'(portMode_ff[offPort[5:0]]);
    end else begin
      unique case (regAddr)
        A_CLASS_EN:   nxt_regRdata = 32'(classReservationEnable_ff);
        A_STICKY_LO:  nxt_regRdata = portDropStickyFlags_ff[31:0];
        A_STICKY_HI:  nxt_regRdata = portDropStickyFlags_ff[63:32];
        A_CPU_DROP:   nxt_regRdata = processorDropCounter_ff;
        A_ENQ_CNT:    nxt_regRdata = enqueuedCopyCounter_ff;
        A_PRESS_DROP: nxt_regRdata = pressureDropCounter_ff;
        A_IQ_SIZE:    nxt_regRdata = 32'(ingressQueueSize);
        A_FREE_REF:   nxt_regRdata = 32'(freeReferenceCount);
        default:      nxt_regRdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      regRdata <= nxt_regRdata;
    end else begin
      regRdata <= 32'h0;
    end
  end

endmodule

// File: bench/bta_threshold_accounting_assertions.sv
`timescale 1ns/1ns
module bta_threshold_accounting_assertions
  import bta_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 57
) (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic [15:0]                   regAddr,
  input wire logic                          regWr,
  input wire logic                          regRd,
  input wire logic [31:0]                   regRdata,
  input wire bta_cmp_req_s                  cmpReq,
  input wire bta_cmp_rsp_s                  cmpRsp,
  input wire bta_red_req_s                  redReq,
  input wire bta_red_rsp_s                  redRsp,
  input wire logic [NUM_PORTS*NUM_PRIO-1:0] pauseRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic pauseHit;
  assign pauseHit = cmpReq.valid && cmpReq.index >= 13'h1000;

  // ==========================================================
  // Pause compare aimed at one port/priority bit
  sequence pauseOne;
    pauseHit && cmpReq.index[12:9] == 4'h8 && cmpReq.index[8:0] < 9'h1c8;
  endsequence

  rd_quiet_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property (
    regRd && regAddr >= 16'h6208 |=> regRdata == 32'h0)
    else $error("unmapped read returned data");
  cmp_answer_a: assert property (cmpReq.valid |=> cmpRsp.valid)
    else $error("compare answer missing");
  cmp_quiet_a: assert property (!cmpReq.valid |=> !cmpRsp.valid)
    else $error("compare answer without request");
  blocks_cause_a: assert property (
    cmpRsp.valid && !cmpRsp.exhausted |-> !cmpRsp.blocks)
    else $error("block without exhausted threshold");
  pause_noblock_a: assert property (pauseHit |=> !cmpRsp.blocks)
    else $error("pause threshold blocked a frame");
  pause_hold_a: assert property (
    !pauseHit && !$past(regWr) |=> $stable(pauseRequest))
    else $error("pause changed without cause");
  pause_bit_a: assert property (pauseOne |=>
    !pauseRequest[$past(cmpReq.index[8:0])] || cmpRsp.exhausted)
    else $error("pause set while memory left");
  red_green_a: assert property (
    redReq.valid && redReq.dropLevel == 2'h0 |=> redRsp.valid && !redRsp.discard)
    else $error("green frame early discarded");
  red_quiet_a: assert property (
    !redReq.valid |=> !redRsp.valid && !redRsp.discard)
    else $error("discard without query");
endmodule

bind bta_threshold_accounting bta_threshold_accounting_assertions #(
  .NUM_PORTS(NUM_PORTS)
) chkr (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .cmpReq(cmpReq), .cmpRsp(cmpRsp),
  .redReq(redReq), .redRsp(redRsp), .pauseRequest(pauseRequest)
);

// File: bench/bta_forwarder_model.sv
`timescale 1ns/1ns
module bta_forwarder_model
  import bta_pkg::*;
(
  input wire logic   clk,
  output bta_cmp_req_s cmpReq,
  input wire bta_cmp_rsp_s cmpRsp,
  output bta_red_req_s redReq,
  input wire bta_red_rsp_s redRsp,
  output bta_event_s fwdEvent
);
  initial begin
    cmpReq = '0;
    redReq = '0;
    fwdEvent = '0;
  end

  // ==========================================================
  // Requests; idle fields inverted so stale values never match
  task automatic compare(input logic [12:0] idx, input logic [15:0] val,
                         output bta_cmp_rsp_s rsp);
    @(posedge clk);
    cmpReq <= '{1'h1, idx, val};
    @(posedge clk);
    cmpReq <= '{1'h0, ~idx, ~val};
    @(negedge clk);
    rsp = cmpRsp;
  endtask

  task automatic early(input logic [5:0] p, input logic [2:0] q,
                       input logic [1:0] dl, input logic [15:0] use_,
                       output bta_red_rsp_s rsp);
    @(posedge clk);
    redReq <= '{1'h1, p, q, dl, use_};
    @(posedge clk);
    redReq <= '{1'h0, ~p, ~q, ~dl, ~use_};
    @(negedge clk);
    rsp = redRsp;
  endtask

  task automatic pulse(input bta_event_s e, input int n);
    @(posedge clk);
    fwdEvent <= e;
    repeat (n) @(posedge clk);
    fwdEvent <= '0;
  endtask
endmodule

// File: bench/bta_threshold_accounting_tb_top.sv
`timescale 1ns/1ns
module bta_threshold_accounting_tb_top
  import bta_pkg::*;
;
  typedef struct packed {
    logic [12:0] idx;
    logic [15:0] thr;
    logic [15:0] val;
    logic        exh;
  } bta_row_s;
  logic         clk;
  logic         rst_n;
  logic [15:0]  regAddr;
  logic [31:0]  regWdata;
  logic         regWr;
  logic         regRd;
  logic [31:0]  regRdata;
  bta_cmp_req_s cmpReq;
  bta_cmp_rsp_s cmpRsp;
  bta_red_req_s redReq;
  bta_red_rsp_s redRsp;
  bta_event_s   fwdEvent;
  logic [15:0]  iqSize;
  logic [15:0]  freeRefs;
  logic [455:0] pauseRequest;
  int           err_total;
  int           n_checks;
  bta_cmp_rsp_s cr;
  bta_red_rsp_s rr;
  logic [31:0]  rdv;
  bta_row_s     r;
  bta_row_s     rows [10];

  bta_threshold_accounting dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmpReq(cmpReq),
    .cmpRsp(cmpRsp), .redReq(redReq), .redRsp(redRsp),
    .fwdEvent(fwdEvent), .ingressQueueSize(iqSize),
    .freeReferenceCount(freeRefs), .pauseRequest(pauseRequest));
  bta_forwarder_model fm (
    .clk(clk), .cmpReq(cmpReq), .cmpRsp(cmpRsp), .redReq(redReq),
    .redRsp(redRsp), .fwdEvent(fwdEvent));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    d = regRdata;
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    rst_n = 1'h0;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'h0;
    regRd = 1'h0;
    iqSize = 16'h1234;
    freeRefs = 16'h0abc;
    err_total = 0;
    n_checks = 0;
    rows = '{'{13'h01c7, 16'h0100, 16'h0100, 1'h1},
             '{13'h01f7, 16'h0200, 16'h01ff, 1'h0},
             '{13'h01fc, 16'h0010, 16'h0011, 1'h1},
             '{13'h01ff, 16'hffff, 16'h0000, 1'h0},
             '{13'h0238, 16'h0000, 16'h0000, 1'h1},
             '{13'h0411, 16'h0040, 16'h0080, 1'h1},
             '{13'h09f0, 16'h1000, 16'h0fff, 1'h0},
             '{13'h0e38, 16'h0001, 16'h0002, 1'h1},
             '{13'h1000, 16'h0008, 16'h0009, 1'h1},
             '{13'h13ff, 16'h7fff, 16'h8000, 1'h1}};
    repeat (20) @(posedge clk);
    chk(regRdata, 32'h0);
    chk({31'h0, |pauseRequest}, 32'h0);
    rst_n <= 1'h1;
    rd(A_PORT_BASE + 16'h5, rdv);
    chk(rdv, {26'h0, PM_RST});
    rd(A_CLASS_EN, rdv);
    chk(rdv, {24'h0, CLASS_EN_RST});
    for (int k = 1; k < 6; k++) begin
      rd(A_CLASS_EN + 16'(k), rdv);
      chk(rdv, 32'h0);
    end
    foreach (rows[i]) begin
      r = rows[i];
      wr(A_CFG_BASE + {3'h0, r.idx}, {16'h0, r.thr});
      wr(A_PEAK_BASE + {3'h0, r.idx}, 32'h0);
      rd(A_CFG_BASE + {3'h0, r.idx}, rdv);
      chk(rdv[15:0], r.thr);
      fm.compare(r.idx, r.val, cr);
      chk(cr.exhausted, r.exh);
      chk(cr.blocks, r.exh && r.idx < 13'h1000);
      fm.compare(r.idx, r.val >> 1, cr);
      rd(A_CUR_BASE + {3'h0, r.idx}, rdv);
      chk(rdv[15:0], r.val >> 1);
      rd(A_PEAK_BASE + {3'h0, r.idx}, rdv);
      chk(rdv[15:0], r.val);
    end

    // ========================================================
    // Status words, read-only and unmapped places
    wr(A_IQ_SIZE, 32'h0);
    rd(A_IQ_SIZE, rdv);
    chk(rdv[15:0], 16'h1234);
    rd(A_FREE_REF, rdv);
    chk(rdv[15:0], 16'h0abc);
    rd(16'h7000, rdv);
    chk(rdv, 32'h0);
    wr(A_PROF_BASE + 16'h47, 32'h12345678);
    rd(A_PROF_BASE + 16'h47, rdv);
    chk(rdv, 32'h12345678);
    rd(A_PROF_BASE + 16'h48, rdv);
    chk(rdv, 32'h0);

    // ========================================================
    // Early discard on group 1, drop level 2, priority 3
    wr(A_PORT_BASE + 16'h2, 32'h39);
    wr(A_PROF_BASE + 16'h23, 32'h0014000a);
    wr(A_CLASS_EN, 32'h08);
    fm.early(6'h02, 3'h3, 2'h2, 16'h0014, rr);
    chk(rr.discard, 1'h1);
    chk({rr.yellowUsesReserved, rr.ingressShareBlock, rr.egressShareBlock,
         rr.classReservationOn}, 4'hf);
    fm.early(6'h02, 3'h3, 2'h2, 16'h000a, rr);
    chk(rr.discard, 1'h0);
    fm.early(6'h02, 3'h3, 2'h0, 16'hffff, rr);
    chk(rr.discard, 1'h0);
    fm.early(6'h07, 3'h3, 2'h1, 16'hffff, rr);
    chk(rr.discard, 1'h0);

    // ========================================================
    // Pause on port 3; port 4 left disabled
    wr(A_PORT_BASE + 16'h3, 32'h07);
    wr(A_CFG_BASE + 16'h101a, 32'h64);
    wr(A_CFG_BASE + 16'h1203, 32'h10);
    wr(A_CFG_BASE + 16'h1204, 32'h0);
    fm.compare(13'h101a, 16'h0064, cr);
    chk(pauseRequest[26], 1'h1);
    chk(cr.blocks, 1'h0);
    fm.compare(13'h101a, 16'h0063, cr);
    chk(pauseRequest[26], 1'h0);
    fm.compare(13'h1203, 16'h0010, cr);
    chk(pauseRequest[31:24], 8'hff);
    fm.compare(13'h1203, 16'h0000, cr);
    chk(pauseRequest[31:24], 8'h00);
    fm.compare(13'h1204, 16'h0000, cr);
    chk(pauseRequest[39:32], 8'h00);

    // ========================================================
    // Event counters and sticky drop flag of port 40
    fm.pulse('{1'h1, 6'h28, 1'h1, 1'h1, 1'h1}, 3);
    fm.pulse('{1'h0, 6'h00, 1'h0, 1'h0, 1'h1}, 2);
    rd(A_CPU_DROP, rdv);
    chk(rdv, 32'h3);
    rd(A_ENQ_CNT, rdv);
    chk(rdv, 32'h5);
    rd(A_PRESS_DROP, rdv);
    chk(rdv, 32'h3);
    wr(A_STICKY_HI, 32'h0);
    rd(A_STICKY_HI, rdv);
    chk(rdv, 32'h100);
    wr(A_STICKY_HI, 32'h100);
    rd(A_STICKY_HI, rdv);
    chk(rdv, 32'h0);
    fork
      fm.pulse('{1'h1, 6'h28, 1'h0, 1'h0, 1'h0}, 1);
      wr(A_STICKY_HI, 32'h100);
    join
    rd(A_STICKY_HI, rdv);
    chk(rdv, 32'h100);
    fork
      fm.pulse('{1'h0, 6'h00, 1'h1, 1'h0, 1'h0}, 1);
      wr(A_CPU_DROP, 32'h0);
    join
    rd(A_CPU_DROP, rdv);
    chk(rdv, 32'h1);
    // Mid-run reset clears pause bits and counters, not arrays
    fm.compare(13'h1203, 16'h0010, cr);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, |pauseRequest}, 32'h0);
    rst_n <= 1'h1;
    rd(A_CPU_DROP, rdv);
    chk(rdv, 32'h0);
    rd(A_CFG_BASE + 16'h1203, rdv);
    chk(rdv, 32'h10);
    complete_run();
  end
endmodule
